/* File: cmo_pkg.sv */
// Constants, types and carriers for the misc-ops and port-select execution block
package cmo_pkg;

    // ==========================================================
    // Instruction fields
    localparam int IC_W = 6;
    localparam int CODE_W = 4;
    localparam int PADDR_W = 13;
    localparam int PWORD_W = 16;
    localparam int PAGE0_ADDR_W = 6;

    localparam logic [5:0] IC_MISC = 6'h3F;
    localparam logic [5:0] IC_PAGE0_READ = 6'h3E;
    // Port-transfer major codes, arbitrary placement in free opcode space
    localparam logic [5:0] IC_PORT_WRITE_PAGE1 = 6'h30;
    localparam logic [5:0] IC_OUT2 = 6'h31;
    localparam logic [5:0] IC_OUT3 = 6'h32;
    localparam logic [5:0] IC_IN1 = 6'h33;
    localparam logic [5:0] IC_IN2 = 6'h34;
    localparam logic [5:0] IC_IN3 = 6'h35;

    // Minor codes in the low nibble of the misc group
    localparam logic [3:0] MN_SHIFT = 4'h0;
    localparam logic [3:0] MN_ROTATE = 4'h1;
    localparam logic [3:0] MN_WAIT = 4'h4;
    localparam logic [3:0] MN_CLK_STOP = 4'h5;
    localparam logic [3:0] MN_SWAP = 4'h6;
    localparam logic [3:0] MN_INTR = 4'h7;
    localparam logic [3:0] MN_PTR_READ = 4'h8;
    localparam logic [3:0] MN_NOP = 4'hF;
    localparam logic [1:0] A_DI = 2'h0;
    localparam logic [1:0] A_EI = 2'h1;
    localparam logic [1:0] A_RET = 2'h3;

    // ==========================================================
    // Port map of internal ports
    localparam logic [1:0] PG1 = 2'd1;
    localparam logic [1:0] PG2 = 2'd2;
    localparam logic [1:0] PG3 = 2'd3;
    localparam logic [3:0] CN_DPORT_WR_MAX = 4'h6;
    localparam logic [3:0] CN_DPORT_RD_MAX = 4'h1;
    localparam logic [3:0] CN_G_LO = 4'h8;
    localparam logic [3:0] CN_G_HI = 4'h9;
    localparam logic [3:0] CN_DSEL = 4'hA;
    localparam logic [3:0] CN_DATA0 = 4'hC;
    localparam logic [3:0] CN_IMF = 4'h2;
    localparam logic [3:0] CN_PTR0 = 4'hC;

    // ==========================================================
    // Timing and reset values
    localparam int MC_CLKS_DEF = 4;
    localparam logic [3:0] PH_ISSUE = 4'h1;
    localparam logic [3:0] PH_CAPT = 4'h2;
    localparam logic [3:0] DSEL_RST = 4'h0;
    localparam logic [7:0] G_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [12:0] PTR_RST = 13'h0000;
    localparam int ISTACK_DEPTH = 4;

    typedef enum logic [1:0] {
        ALU_SHR,
        ALU_ROR,
        ALU_SWAP
    } cmo_alu_e;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_SHIFT,
        OP_ROTATE,
        OP_SWAP,
        OP_PAGE0_READ,
        OP_PTR_READ,
        OP_WAIT,
        OP_CLK_STOP,
        OP_NOP,
        OP_OUT,
        OP_IN,
        OP_EI,
        OP_DI,
        OP_RET
    } cmo_op_e;

    typedef struct packed {
        logic [5:0] ic;
        logic [1:0] a;
        logic [3:0] b;
        logic [3:0] c;
    } cmo_ins_s;

    typedef struct packed {
        logic [1:0] page;
        logic [3:0] code;
        logic [3:0] dsel;
        logic [3:0] data;
    } cmo_port_s;

endpackage

/* File: cmo_nibble_alu.sv */
// Nibble shift, rotate and bit-swap datapath
`timescale 1ns/1ps
`default_nettype none
module cmo_nibble_alu (
    input wire cmo_pkg::cmo_alu_e sel,
    input wire logic [3:0] m,
    input wire logic cy_in,
    output logic [3:0] res,
    output logic cy_out
);
    import cmo_pkg::*;

    always_comb begin
        res = m;
        cy_out = cy_in;
        unique case (sel)
            ALU_SHR: begin
                res = {1'b0, m[3:1]};
                cy_out = m[0];
            end
            ALU_ROR: begin
                res = {cy_in, m[3:1]};
                cy_out = m[0];
            end
            ALU_SWAP: begin
                res = {m[0], m[1], m[2], m[3]};
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: cmo_core.sv */
// Execution of misc ops, table reads and internal port selection
//
// What this block does
// - shift nibble right, zero in, bit0 to carry
// - rotate through carry; swap bits 3-0, 2-1
// - page-zero read: immediate plus register into data
// - pointer read loads data, pointer increments
// - table pointer reachable as a port
// - table reads two machine cycles, others one
// - clock-stop halts generator per mode
// - ports chosen by six instructions plus code
// - G, data, pointer reachable as ports
// - unimplemented output write changes nothing
// - unimplemented input read returns anything
// - unused output ports accept writes harmlessly
// - Y1 is LSB, Y8 is MSB
// - port id is direction, page, code
// - G-register written at page1 codes 8,9
// - data port: 16 slots, write 0-6, read 0-1
// - data select increments per data port access
// - data select is port code A page1
// - data select saved on interrupt, restored on return
// - interrupt master enable lives in port map
`timescale 1ns/1ps
`default_nettype none
module cmo_core #(
    parameter int MC_CLKS = cmo_pkg::MC_CLKS_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire cmo_pkg::cmo_ins_s instr,
    input wire logic [3:0] mem_rd_data,
    input wire logic [3:0] gr_rd_data,
    input wire logic [cmo_pkg::PWORD_W-1:0] pmem_data,
    input wire logic [3:0] ext_rd_data,
    input wire logic int_req,
    input wire logic [1:0] int_sp,
    input wire logic wake,
    input wire logic [1:0] stop_mode,
    output logic busy_r,
    output logic instr_done_r,
    output logic mem_wr_en_r,
    output logic [3:0] mem_wr_data_r,
    output logic carry_flag_r,
    output logic pmem_rd_r,
    output logic [cmo_pkg::PADDR_W-1:0] pmem_addr_r,
    output logic ext_wr_r,
    output logic ext_rd_r,
    output cmo_pkg::cmo_port_s ext_port_r,
    output logic [cmo_pkg::PWORD_W-1:0] data_r,
    output logic [7:0] g_reg_r,
    output logic [cmo_pkg::PADDR_W-1:0] table_address_pointer_r,
    output logic [3:0] data_sel_r,
    output logic interrupt_master_enable_r,
    output logic cpu_wait_r,
    output logic hard_wait_r,
    output logic clock_stop_r,
    output logic [1:0] stop_mode_r
);
    import cmo_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_meta_r;
    logic rst_sync_n_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // Decode helpers
    function automatic cmo_op_e decode(input cmo_ins_s i);
        cmo_op_e op;
        op = OP_NONE;
        if (i.ic == IC_PAGE0_READ) begin
            op = OP_PAGE0_READ;
        end else if (i.ic == IC_MISC) begin
            if (i.c == MN_SHIFT) op = OP_SHIFT;
            else if (i.c == MN_ROTATE) op = OP_ROTATE;
            else if (i.c == MN_SWAP) op = OP_SWAP;
            else if (i.c == MN_PTR_READ) op = OP_PTR_READ;
            else if (i.c == MN_WAIT) op = OP_WAIT;
            else if (i.c == MN_CLK_STOP) op = OP_CLK_STOP;
            else if (i.c == MN_NOP) op = OP_NOP;
            else if (i.c == MN_INTR && i.a == A_DI) op = OP_DI;
            else if (i.c == MN_INTR && i.a == A_EI) op = OP_EI;
            else if (i.c == MN_INTR && i.a == A_RET) op = OP_RET;
        end else if (i.ic == IC_PORT_WRITE_PAGE1 || i.ic == IC_OUT2 || i.ic == IC_OUT3) begin
            op = OP_OUT;
        end else if (i.ic == IC_IN1 || i.ic == IC_IN2 || i.ic == IC_IN3) begin
            op = OP_IN;
        end
        return op;
    endfunction

    // page from opcode, direction from op
    function automatic logic [1:0] page_of(input logic [5:0] ic);
        logic [1:0] pg;
        pg = PG1;
        if (ic == IC_OUT2 || ic == IC_IN2) pg = PG2;
        else if (ic == IC_OUT3 || ic == IC_IN3) pg = PG3;
        return pg;
    endfunction

    function automatic logic is_dport(input logic [1:0] pg, input logic [3:0] cn,
                                      input logic wr);
        return pg == PG1 && (wr ? cn <= CN_DPORT_WR_MAX : cn <= CN_DPORT_RD_MAX);
    endfunction

    function automatic logic is_int_wr(input logic [1:0] pg, input logic [3:0] cn);
        return (pg == PG1 && (cn == CN_G_LO || cn == CN_G_HI || cn == CN_DSEL))
            || (pg == PG2 && cn == CN_IMF)
            || (pg == PG3 && cn >= CN_PTR0);
    endfunction

    function automatic logic is_int_rd(input logic [1:0] pg, input logic [3:0] cn);
        return (pg == PG1 && (cn == CN_G_LO || cn == CN_G_HI || cn == CN_DSEL
                              || cn >= CN_DATA0))
            || (pg == PG2 && cn == CN_IMF);
    endfunction

    // ==========================================================
    // Instruction sequencing
    cmo_ins_s ir_r;
    cmo_op_e op_r;
    logic [3:0] m_r;
    logic [3:0] gr_r;
    logic [3:0] cyc_r;
    logic [3:0] last_r;
    logic [PWORD_W-1:0] cap_r;
    logic [1:0] page;
    logic [3:0] cn;
    logic take;
    logic commit;
    logic table_op;
    logic dport_hit;
    logic ext_access;

    assign page = page_of(ir_r.ic);
    assign cn = ir_r.c;
    assign take = !busy_r && instr_valid && !cpu_wait_r && !hard_wait_r;
    assign commit = busy_r && cyc_r == last_r;
    assign table_op = op_r == OP_PAGE0_READ || op_r == OP_PTR_READ;
    assign dport_hit = (op_r == OP_OUT && is_dport(page, cn, 1'b1))
        || (op_r == OP_IN && is_dport(page, cn, 1'b0));
    assign ext_access = (op_r == OP_OUT && !is_int_wr(page, cn))
        || (op_r == OP_IN && !is_int_rd(page, cn));

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            busy_r <= 1'b0;
            instr_done_r <= 1'b0;
            ir_r <= '0;
            op_r <= OP_NONE;
            m_r <= 4'h0;
            gr_r <= 4'h0;
            cyc_r <= 4'h0;
            last_r <= 4'h0;
        end else begin
            instr_done_r <= commit;
            if (take) begin
                busy_r <= 1'b1;
                ir_r <= instr;
                op_r <= decode(instr);
                m_r <= mem_rd_data;
                gr_r <= gr_rd_data;
                cyc_r <= 4'h0;
                // table reads run for two machine cycles
                if (decode(instr) == OP_PAGE0_READ || decode(instr) == OP_PTR_READ) begin
                    last_r <= 4'(2 * MC_CLKS - 1);
                end else begin
                    last_r <= 4'(MC_CLKS - 1);
                end
            end else if (busy_r) begin
                cyc_r <= cyc_r + 4'h1;
                if (commit) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Program memory fetch for table reads
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            pmem_rd_r <= 1'b0;
            pmem_addr_r <= PTR_RST;
        end else begin
            pmem_rd_r <= 1'b0;
            if (busy_r && cyc_r == PH_ISSUE && table_op) begin
                pmem_rd_r <= 1'b1;
                if (op_r == OP_PAGE0_READ) begin
                    pmem_addr_r <= PADDR_W'({ir_r.a, ir_r.b}) + PADDR_W'(gr_r);
                end else begin
                    pmem_addr_r <= table_address_pointer_r;
                end
            end
        end
    end

    // Answers land one clock after the strobe
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cap_r <= DATA_RST;
        end else if (busy_r && cyc_r == PH_CAPT) begin
            if (table_op) begin
                cap_r <= pmem_data;
            end else if (ext_access) begin
                // whatever the peripheral returns is taken
                cap_r <= PWORD_W'(ext_rd_data);
            end else begin
                cap_r <= PWORD_W'(int_read(cn));
            end
        end
    end

    function automatic logic [3:0] int_read(input logic [3:0] c);
        logic [3:0] v;
        v = 4'h0;
        if (page == PG2) begin
            v = {3'b000, interrupt_master_enable_r};
        end else begin
            unique case (c)
                CN_G_LO: v = g_reg_r[3:0];
                CN_G_HI: v = g_reg_r[7:4];
                CN_DSEL: v = data_sel_r;
                // data register nibbles, low code first
                4'hC: v = data_r[3:0];
                4'hD: v = data_r[7:4];
                4'hE: v = data_r[11:8];
                4'hF: v = data_r[15:12];
                default: v = 4'h0;
            endcase
        end
        return v;
    endfunction

    // ==========================================================
    // Peripheral port strobes
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            ext_wr_r <= 1'b0;
            ext_rd_r <= 1'b0;
            ext_port_r <= '0;
        end else begin
            ext_wr_r <= 1'b0;
            ext_rd_r <= 1'b0;
            if (busy_r && cyc_r == PH_ISSUE && ext_access) begin
                // unused codes strobed out all the same
                ext_wr_r <= op_r == OP_OUT;
                ext_rd_r <= op_r == OP_IN;
                // data port slot chosen by the data select
                ext_port_r <= '{page: page, code: cn, dsel: data_sel_r, data: m_r};
            end
        end
    end

    // ==========================================================
    // Data memory write-back and carry
    logic [3:0] alu_res;
    logic alu_cy;
    cmo_alu_e alu_sel;

    assign alu_sel = op_r == OP_SHIFT ? ALU_SHR : (op_r == OP_ROTATE ? ALU_ROR : ALU_SWAP);

    cmo_nibble_alu u_alu (
        .sel(alu_sel),
        .m(m_r),
        .cy_in(carry_flag_r),
        .res(alu_res),
        .cy_out(alu_cy)
    );

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            mem_wr_en_r <= 1'b0;
            mem_wr_data_r <= 4'h0;
            carry_flag_r <= 1'b0;
        end else begin
            mem_wr_en_r <= 1'b0;
            if (commit) begin
                if (op_r == OP_SHIFT || op_r == OP_ROTATE || op_r == OP_SWAP) begin
                    mem_wr_en_r <= 1'b1;
                    mem_wr_data_r <= alu_res;
                end else if (op_r == OP_IN) begin
                    // port bit Y1 lands in nibble bit 0
                    mem_wr_en_r <= 1'b1;
                    mem_wr_data_r <= cap_r[3:0];
                end
                if (op_r == OP_SHIFT || op_r == OP_ROTATE) begin
                    carry_flag_r <= alu_cy;
                end
            end
        end
    end

    // ==========================================================
    // Data register and table pointer
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            data_r <= DATA_RST;
        end else if (commit && table_op) begin
            data_r <= cap_r;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            table_address_pointer_r <= PTR_RST;
        end else if (commit && op_r == OP_PTR_READ) begin
            table_address_pointer_r <= table_address_pointer_r + PADDR_W'(1);
        end else if (commit && op_r == OP_OUT && page == PG3 && cn >= CN_PTR0) begin
            // pointer written per nibble via ports
            unique case (cn)
                4'hC: table_address_pointer_r[3:0] <= m_r;
                4'hD: table_address_pointer_r[7:4] <= m_r;
                4'hE: table_address_pointer_r[11:8] <= m_r;
                default: table_address_pointer_r[12] <= m_r[0];
            endcase
        end
    end

    // ==========================================================
    // G-register and interrupt master enable
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            g_reg_r <= G_RST;
        end else if (commit && op_r == OP_OUT && page == PG1) begin
            // G-register halves at codes 8 and 9
            if (cn == CN_G_LO) g_reg_r[3:0] <= m_r;
            if (cn == CN_G_HI) g_reg_r[7:4] <= m_r;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            interrupt_master_enable_r <= 1'b0;
        end else if (commit && (op_r == OP_EI || op_r == OP_RET)) begin
            interrupt_master_enable_r <= 1'b1;
        end else if (commit && op_r == OP_OUT && page == PG2 && cn == CN_IMF) begin
            // enable written as a port bit
            interrupt_master_enable_r <= m_r[0];
        end else if (int_req || (commit && op_r == OP_DI)) begin
            interrupt_master_enable_r <= 1'b0;
        end
    end

    // ==========================================================
    // Data select pointer with interrupt save area
    logic [3:0] dsel_stack_r [ISTACK_DEPTH];

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            for (int k = 0; k < ISTACK_DEPTH; k++) begin
                dsel_stack_r[k] <= DSEL_RST;
            end
        end else if (int_req) begin
            // save pointer at the stack entry
            dsel_stack_r[int_sp] <= data_sel_r;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            data_sel_r <= DSEL_RST;
        end else if (commit && op_r == OP_RET) begin
            data_sel_r <= dsel_stack_r[int_sp];
        end else if (commit && op_r == OP_OUT && page == PG1 && cn == CN_DSEL) begin
            data_sel_r <= m_r;
        end else if (commit && dport_hit) begin
            // advance after each data port access
            data_sel_r <= data_sel_r + 4'h1;
        end
    end

    // ==========================================================
    // Wait and clock-stop requests
    // Held until wake; a wake in the commit cycle loses to the commit
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cpu_wait_r <= 1'b0;
            hard_wait_r <= 1'b0;
        end else if (commit && op_r == OP_WAIT) begin
            // operand selects soft or hard wait
            cpu_wait_r <= !ir_r.a[0];
            hard_wait_r <= ir_r.a[0];
        end else if (wake) begin
            cpu_wait_r <= 1'b0;
            hard_wait_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            clock_stop_r <= 1'b0;
            stop_mode_r <= 2'b00;
        end else if (commit && op_r == OP_CLK_STOP) begin
            // stop request carries the configured mode
            clock_stop_r <= 1'b1;
            stop_mode_r <= stop_mode;
        end else if (wake) begin
            clock_stop_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: cmo_core_monitor.sv */
// Assertion checker for the misc-ops and port-select block
`timescale 1ns/1ps
`default_nettype none
module cmo_core_monitor
    import cmo_pkg::*;
#(
    parameter int MC_CLKS = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire cmo_pkg::cmo_ins_s instr,
    input wire logic [3:0] mem_rd_data,
    input wire logic busy_r,
    input wire logic instr_done_r,
    input wire logic mem_wr_en_r,
    input wire logic [3:0] mem_wr_data_r,
    input wire logic carry_flag_r,
    input wire logic [12:0] table_address_pointer_r,
    input wire logic [3:0] data_sel_r,
    input wire logic [7:0] g_reg_r,
    input wire logic cpu_wait_r,
    input wire logic hard_wait_r,
    input wire logic ext_wr_r,
    input wire cmo_pkg::cmo_port_s ext_port_r
);
    localparam int D1 = MC_CLKS + 1;
    localparam int T1 = 2 * MC_CLKS + 1;
    logic take, misc, tbl, a0_r, cy_r;
    logic [3:0] m_r, ds_r;
    logic [12:0] p_r;
    assign take = instr_valid && !busy_r && !cpu_wait_r && !hard_wait_r;
    assign misc = take && instr.ic == IC_MISC;
    assign tbl = misc && instr.c == MN_PTR_READ || take && instr.ic == IC_PAGE0_READ;
    // Operands held from the take edge until commit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {a0_r, cy_r, m_r, ds_r, p_r} <= '0;
        end else if (take) begin
            {a0_r, cy_r, m_r, ds_r, p_r} <= {instr.a[0], carry_flag_r, mem_rd_data,
                data_sel_r, table_address_pointer_r};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_shift_zero_fill: assert property (
        misc && instr.c == MN_SHIFT |-> ##D1 mem_wr_en_r
            && {mem_wr_data_r, carry_flag_r} == {1'b0, m_r}) else $error("shift wrong");
    a_rotate_carry: assert property (
        misc && instr.c == MN_ROTATE |-> ##D1 mem_wr_en_r
            && {mem_wr_data_r, carry_flag_r} == {cy_r, m_r}) else $error("rotate wrong");
    a_swap_bits: assert property (
        misc && instr.c == MN_SWAP |-> ##D1 mem_wr_en_r && {mem_wr_data_r, carry_flag_r}
            == {m_r[0], m_r[1], m_r[2], m_r[3], cy_r}) else $error("swap wrong");
    a_ptr_increment: assert property (
        misc && instr.c == MN_PTR_READ |-> ##T1 table_address_pointer_r == p_r + 13'h0001)
        else $error("pointer not stepped");
    a_table_two_mc: assert property (
        tbl |-> ##T1 instr_done_r) else $error("table timing wrong");
    a_single_one_mc: assert property (
        take && !tbl |-> ##D1 instr_done_r) else $error("single timing wrong");
    a_dsel_step: assert property (
        take && instr.ic == IC_PORT_WRITE_PAGE1 && instr.c <= CN_DPORT_WR_MAX |-> ##D1
            data_sel_r == ds_r + 4'h1) else $error("data select not stepped");
    a_ext_dsel_tag: assert property (
        ext_wr_r && ext_port_r.page == PG1 && ext_port_r.code <= CN_DPORT_WR_MAX
            |-> ext_port_r.dsel == data_sel_r) else $error("data port slot wrong");
    a_g_high_write: assert property (
        take && instr.ic == IC_PORT_WRITE_PAGE1 && instr.c == CN_G_HI |-> ##D1 g_reg_r[7:4] == m_r)
        else $error("g high nibble wrong");
    a_wait_kind: assert property (
        misc && instr.c == MN_WAIT |-> ##D1 hard_wait_r == a0_r && (a0_r || cpu_wait_r))
        else $error("wait kind wrong");
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the misc-ops and port-select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cmo_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, int_req = 1'b0, wake = 1'b0;
    cmo_ins_s instr = '0;
    logic [3:0] mem_rd_data = 4'h0, gr_rd_data = 4'h0, ext_rd_data = 4'h0;
    logic [15:0] pmem_data = 16'h0000;
    logic [1:0] int_sp = 2'h0, stop_mode = 2'h0;
    logic busy_r, instr_done_r, mem_wr_en_r, carry_flag_r, pmem_rd_r, ext_wr_r, ext_rd_r;
    logic interrupt_master_enable_r, cpu_wait_r, hard_wait_r, clock_stop_r;
    logic [3:0] mem_wr_data_r, data_sel_r, rm, mem_cap = 4'h0, e_mem = 4'h0, e_ds = 4'h0;
    logic [12:0] pmem_addr_r, table_address_pointer_r, e_ptr = '0, e_pa = '0;
    logic [15:0] data_r, e_data = '0;
    logic [7:0] g_reg_r, e_g = '0;
    logic [1:0] stop_mode_r, e_sm = '0;
    logic e_cy = 1'b0, e_imf = 1'b0, e_hw = 1'b0, e_cs = 1'b0;
    cmo_port_s ext_port_r;
    logic [62:0] exp_q[$];
    logic [62:0] got, want;
    int fails = 0, comparisons = 0, cyc = 0, seed = 58, i;

    cmo_core #(.MC_CLKS(4)) u_dut (.clock, .rst_n, .instr_valid, .instr, .mem_rd_data,
        .gr_rd_data, .pmem_data, .ext_rd_data, .int_req, .int_sp, .wake, .stop_mode,
        .busy_r, .instr_done_r, .mem_wr_en_r, .mem_wr_data_r, .carry_flag_r, .pmem_rd_r,
        .pmem_addr_r, .ext_wr_r, .ext_rd_r, .ext_port_r, .data_r, .g_reg_r,
        .table_address_pointer_r, .data_sel_r, .interrupt_master_enable_r, .cpu_wait_r,
        .hard_wait_r, .clock_stop_r, .stop_mode_r);

    always #12.5 clock = ~clock;

    task automatic end_sim();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            end_sim();
        end
    end

    // ==========================================================
    // Result watcher, one note per completed instruction
    always @(negedge clock) begin
        if (mem_wr_en_r === 1'b1) mem_cap = mem_wr_data_r;
        if (instr_done_r === 1'b1) begin
            got = {mem_cap, carry_flag_r, data_r, data_sel_r, table_address_pointer_r,
                g_reg_r, hard_wait_r, clock_stop_r, stop_mode_r, interrupt_master_enable_r,
                pmem_addr_r};
            want = exp_q.pop_front();
            comparisons++;
            if (got !== want) begin
                fails++;
                $display("[ERR] state exp=%h got=%h", want, got);
            end
        end
    end

    // ==========================================================
    // Driver: note expectation, offer instruction, await done
    task automatic op(input logic [5:0] ic, input logic [3:0] c, m,
        input logic [1:0] a = 2'h0, input logic [3:0] b = 4'h0);
        int n;
        @(negedge clock);
        instr = '{ic, a, b, c};
        mem_rd_data = m;
        instr_valid = 1'b1;
        exp_q.push_back({e_mem, e_cy, e_data, e_ds, e_ptr, e_g, e_hw, e_cs, e_sm, e_imf, e_pa});
        @(negedge clock);
        instr_valid = 1'b0;
        for (n = 0; n < 20 && instr_done_r !== 1'b1; n++) @(negedge clock);
    endtask

    task automatic wake_up();
        @(negedge clock);
        wake = 1'b1;
        @(negedge clock);
        wake = 1'b0;
        {e_hw, e_cs} = 2'b00;
    endtask

    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        e_imf = 1'b1;
        op(IC_MISC, MN_INTR, 4'h0, A_EI);
        for (i = 0; i < 6; i++) begin
            rm = 4'($random(seed));
            {e_mem, e_cy} = {1'b0, rm};
            op(IC_MISC, MN_SHIFT, rm);
            rm = 4'($random(seed));
            {e_mem, e_cy} = {e_cy, rm};
            op(IC_MISC, MN_ROTATE, rm);
            rm = 4'($random(seed));
            e_mem = {rm[0], rm[1], rm[2], rm[3]};
            op(IC_MISC, MN_SWAP, rm);
        end
        e_g = 8'h05;
        op(IC_PORT_WRITE_PAGE1, CN_G_LO, 4'h5);
        e_g = 8'hA5;
        op(IC_PORT_WRITE_PAGE1, CN_G_HI, 4'hA);
        e_mem = 4'h5;
        op(IC_IN1, CN_G_LO, 4'h0);
        e_ds = 4'hE;
        op(IC_PORT_WRITE_PAGE1, CN_DSEL, 4'hE);
        for (i = 0; i < 7; i++) begin
            e_ds++;
            op(IC_PORT_WRITE_PAGE1, 4'(i), 4'($random(seed)));
        end
        ext_rd_data = 4'h6;
        e_mem = 4'h6;
        for (i = 0; i < 2; i++) begin
            e_ds++;
            op(IC_IN1, 4'(i), 4'h0);
        end
        e_mem = e_ds;
        op(IC_IN1, CN_DSEL, 4'h0);
        op(IC_OUT2, 4'h5, 4'hF);
        op(IC_MISC, MN_NOP, 4'hF);
        for (i = 0; i < 4; i++) begin
            if (i < 3) e_ptr[4*i+:4] = 4'hF;
            else e_ptr[12] = 1'b1;
            op(IC_OUT3, 4'(12 + i), 4'hF);
        end
        pmem_data = 16'hA5C3;
        {e_data, e_pa, e_ptr} = {16'hA5C3, 13'h1FFF, 13'h0000};
        op(IC_MISC, MN_PTR_READ, 4'h0);
        for (i = 0; i < 4; i++) begin
            e_mem = e_data[4*i+:4];
            op(IC_IN1, 4'(12 + i), 4'h0);
        end
        gr_rd_data = 4'h3;
        pmem_data = 16'h5A3C;
        {e_data, e_pa} = {16'h5A3C, 13'h0015};
        op(IC_PAGE0_READ, 4'h7, 4'h0, 2'h1, 4'h2);
        e_ds = 4'h5;
        op(IC_PORT_WRITE_PAGE1, CN_DSEL, 4'h5);
        @(negedge clock);
        {int_sp, int_req} = 3'b101;
        @(negedge clock);
        int_req = 1'b0;
        {e_imf, e_ds} = 5'h09;
        op(IC_PORT_WRITE_PAGE1, CN_DSEL, 4'h9);
        {e_imf, e_ds} = 5'h15;
        op(IC_MISC, MN_INTR, 4'h0, A_RET);
        e_imf = 1'b0;
        op(IC_OUT2, CN_IMF, 4'h0);
        e_mem = 4'h0;
        op(IC_IN2, CN_IMF, 4'hF);
        op(IC_MISC, MN_WAIT, 4'h0);
        wake_up();
        e_hw = 1'b1;
        op(IC_MISC, MN_WAIT, 4'h0, 2'h1);
        wake_up();
        stop_mode = 2'h2;
        {e_cs, e_sm} = 3'b110;
        op(IC_MISC, MN_CLK_STOP, 4'h0);
        wake_up();
        repeat (4) @(negedge clock);
        if (exp_q.size() != 0) fails++;
        end_sim();
    end
endmodule

bind cmo_core cmo_core_monitor #(.MC_CLKS(MC_CLKS)) u_mon (.clock, .rst_n, .instr_valid,
    .instr, .mem_rd_data, .busy_r, .instr_done_r, .mem_wr_en_r, .mem_wr_data_r, .carry_flag_r,
    .table_address_pointer_r, .data_sel_r, .g_reg_r, .cpu_wait_r, .hard_wait_r, .ext_wr_r,
    .ext_port_r);
`default_nettype wire
